/* File: ovpc_pkg.sv */
// Constants and types for the over-voltage protection setup block
`default_nettype none
package ovpc_pkg;
  // Register map
  localparam logic [7:0] SETUP_OFS = 8'h0d;
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  // Field positions
  localparam int IN_HYS_BIT = 7;
  localparam int IN_THR_LSB = 5;
  localparam int OUT_REC_BIT = 4;
  localparam int OUT_THR_LSB = 2;
  localparam int FB_CON_BIT = 1;
  localparam int MODE_BIT = 0;
  // Serial bus address of the device, arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h20;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RETRY_DELAY_NS = 2000;
  localparam int RETRY_DELAY_CYC =
    (RETRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_W = 5;
  // Serial bus slave states
  typedef enum logic [3:0] {
    I_IDLE, I_ADDR, I_AACK, I_PTR, I_PACK, I_WDATA, I_WACK, I_RDATA, I_RACK
  } ovpc_i2c_t;
  // Protection states
  typedef enum logic [1:0] {
    PR_OFF, PR_RUN, PR_STOP, PR_LATCH
  } ovpc_prot_t;
endpackage
`default_nettype wire

/* File: ovpc_sync.sv */
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ns
`default_nettype none
module ovpc_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ovpc_sync_t;

  ovpc_sync_t st_r;
  ovpc_sync_t st_nxt;

  // First stage is read by the second stage only
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  // State register, frozen while the enable is low
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule
`default_nettype wire

/* File: ovpc_top.sv */
// Over-voltage protection setup register with serial slave and OV handling
`timescale 1ns/1ns
`default_nettype none
module ovpc_top #(
  parameter int RETRY_CYC = ovpc_pkg::RETRY_DELAY_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe_n,
  input wire logic enable_pin,
  input wire logic vin_ov_cmp,
  input wire logic vout_ov_cmp,
  output logic input_ov_hysteresis_sel,
  output logic [1:0] input_ov_threshold_sel,
  output logic output_ov_recovery_sel,
  output logic [1:0] output_ov_threshold_sel,
  output logic feedback_pin_connect,
  output logic output_ov_response_mode,
  output logic switch_enable,
  output logic soft_start_req,
  output logic hiccup_active,
  output logic latched_off
);
  typedef struct packed {
    logic [7:0] setup;
    logic scl_q;
    logic sda_q;
    ovpc_pkg::ovpc_i2c_t ist;
    logic [2:0] bcnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic drv_low;
    logic ack_ok;
    ovpc_pkg::ovpc_prot_t pst;
    logic [15:0] dly;
    logic retried;
    logic hiccup;
    logic sw_en;
    logic ss_req;
  } ovpc_state_t;

  localparam ovpc_state_t ST_RST = '{
    setup: ovpc_pkg::SETUP_RST, scl_q: 1'h1, sda_q: 1'h1,
    ist: ovpc_pkg::I_IDLE, bcnt: 3'h0, sh: 8'h00, ptr: 8'h00,
    rw: 1'h0, drv_low: 1'h0, ack_ok: 1'h0, pst: ovpc_pkg::PR_OFF,
    dly: 16'h0000, retried: 1'h0, hiccup: 1'h0, sw_en: 1'h0,
    ss_req: 1'h0};

  ovpc_state_t st_r;
  ovpc_state_t st_nxt;
  logic [ovpc_pkg::SYNC_W-1:0] sync_q;
  logic scl_s, sda_s, en_s, vin_s, vout_s;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [7:0] rx_byte, rd_byte;
  logic wr_fire;

  // All pins cross into the clock domain before use; bus lines cross
  // inverted so the synchroniser's reset matches their idle high level
  // and no false edge is seen after reset
  ovpc_sync #(
    .W(ovpc_pkg::SYNC_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ce(ce),
    .d({~scl_pin, ~sda_pin_in, enable_pin, vin_ov_cmp, vout_ov_cmp}),
    .q(sync_q)
  );

  // Bus edge and condition decode on synchronised levels
  assign {scl_s, sda_s, en_s, vin_s, vout_s} = sync_q ^ 5'h18;
  assign scl_rise = scl_s && !st_r.scl_q;
  assign scl_fall = !scl_s && st_r.scl_q;
  assign start_det = scl_s && st_r.scl_q && st_r.sda_q && !sda_s;
  assign stop_det = scl_s && st_r.scl_q && !st_r.sda_q && sda_s;
  assign rx_byte = {st_r.sh[6:0], sda_s};
  // Only the setup register lives here; other addresses read as zero
  assign rd_byte = (st_r.ptr == ovpc_pkg::SETUP_OFS) ?
                   st_r.setup : ovpc_pkg::UNMAPPED_RD;
  assign wr_fire = scl_rise && (st_r.ist == ovpc_pkg::I_WDATA) &&
                   (st_r.bcnt == 3'h7) && (st_r.ptr == ovpc_pkg::SETUP_OFS);

  // Next-state logic for bus slave and protection sequencer
  always_comb begin
    st_nxt = st_r;
    st_nxt.scl_q = scl_s;
    st_nxt.sda_q = sda_s;
    st_nxt.ss_req = 1'h0;
    if (start_det) begin
      st_nxt.ist = ovpc_pkg::I_ADDR;
      st_nxt.bcnt = 3'h0;
      st_nxt.drv_low = 1'h0;
    end else if (stop_det) begin
      st_nxt.ist = ovpc_pkg::I_IDLE;
      st_nxt.drv_low = 1'h0;
    end else if (scl_rise) begin
      unique case (st_r.ist)
        ovpc_pkg::I_ADDR, ovpc_pkg::I_PTR, ovpc_pkg::I_WDATA: begin
          st_nxt.sh = rx_byte;
          st_nxt.bcnt = st_r.bcnt + 3'h1;
          if (st_r.bcnt == 3'h7) begin
            if (st_r.ist == ovpc_pkg::I_ADDR) begin
              st_nxt.rw = rx_byte[0];
              st_nxt.ist = (rx_byte[7:1] == ovpc_pkg::DEV_ADDR) ?
                           ovpc_pkg::I_AACK : ovpc_pkg::I_IDLE;
            end else if (st_r.ist == ovpc_pkg::I_PTR) begin
              st_nxt.ptr = rx_byte;
              st_nxt.ist = ovpc_pkg::I_PACK;
            end else begin
              if (wr_fire) begin
                st_nxt.setup = rx_byte;
              end
              st_nxt.ptr = st_r.ptr + 8'h01;
              st_nxt.ist = ovpc_pkg::I_WACK;
            end
          end
        end
        ovpc_pkg::I_RACK: st_nxt.ack_ok = !sda_s;
        ovpc_pkg::I_IDLE, ovpc_pkg::I_AACK, ovpc_pkg::I_PACK,
        ovpc_pkg::I_WACK, ovpc_pkg::I_RDATA: begin
        end
        default: st_nxt.ist = ovpc_pkg::I_IDLE;
      endcase
    end else if (scl_fall) begin
      unique case (st_r.ist)
        ovpc_pkg::I_AACK, ovpc_pkg::I_PACK, ovpc_pkg::I_WACK: begin
          if (!st_r.drv_low) begin
            st_nxt.drv_low = 1'h1;
          end else begin
            st_nxt.drv_low = 1'h0;
            st_nxt.bcnt = 3'h0;
            if (st_r.ist == ovpc_pkg::I_AACK && st_r.rw) begin
              st_nxt.sh = rd_byte;
              st_nxt.drv_low = !rd_byte[7];
              st_nxt.ptr = st_r.ptr + 8'h01;
              st_nxt.ist = ovpc_pkg::I_RDATA;
            end else if (st_r.ist == ovpc_pkg::I_AACK) begin
              st_nxt.ist = ovpc_pkg::I_PTR;
            end else begin
              st_nxt.ist = ovpc_pkg::I_WDATA;
            end
          end
        end
        ovpc_pkg::I_RDATA: begin
          if (st_r.bcnt == 3'h7) begin
            st_nxt.drv_low = 1'h0;
            st_nxt.ack_ok = 1'h0;
            st_nxt.ist = ovpc_pkg::I_RACK;
          end else begin
            st_nxt.bcnt = st_r.bcnt + 3'h1;
            st_nxt.sh = {st_r.sh[6:0], 1'h0};
            st_nxt.drv_low = !st_r.sh[6];
          end
        end
        ovpc_pkg::I_RACK: begin
          if (st_r.ack_ok) begin
            st_nxt.sh = rd_byte;
            st_nxt.drv_low = !rd_byte[7];
            st_nxt.bcnt = 3'h0;
            st_nxt.ptr = st_r.ptr + 8'h01;
            st_nxt.ist = ovpc_pkg::I_RDATA;
          end else begin
            st_nxt.ist = ovpc_pkg::I_IDLE;
          end
        end
        ovpc_pkg::I_IDLE, ovpc_pkg::I_ADDR, ovpc_pkg::I_PTR,
        ovpc_pkg::I_WDATA: begin
        end
        default: st_nxt.ist = ovpc_pkg::I_IDLE;
      endcase
    end

    // Output over-voltage sequencer; mode is sampled at each trip
    unique case (st_r.pst)
      ovpc_pkg::PR_OFF: begin
        if (en_s) begin
          st_nxt.pst = ovpc_pkg::PR_RUN;
          st_nxt.ss_req = 1'h1;
          st_nxt.retried = 1'h0;
          st_nxt.hiccup = 1'h0;
        end
      end
      ovpc_pkg::PR_RUN: begin
        if (!en_s) begin
          st_nxt.pst = ovpc_pkg::PR_OFF;
        end else if (vout_s) begin
          if (st_r.setup[ovpc_pkg::MODE_BIT]) begin
            st_nxt.pst = ovpc_pkg::PR_LATCH;
          end else begin
            st_nxt.pst = ovpc_pkg::PR_STOP;
            st_nxt.dly = 16'h0000;
            if (st_r.retried) begin
              st_nxt.hiccup = 1'h1;
            end
          end
        end
      end
      ovpc_pkg::PR_STOP: begin
        if (!en_s) begin
          st_nxt.pst = ovpc_pkg::PR_OFF;
        end else if (st_r.dly == 16'(RETRY_CYC - 1)) begin
          st_nxt.pst = ovpc_pkg::PR_RUN;
          st_nxt.ss_req = 1'h1;
          st_nxt.retried = 1'h1;
        end else begin
          st_nxt.dly = st_r.dly + 16'h0001;
        end
      end
      ovpc_pkg::PR_LATCH: begin
        // only an enable low releases the latch
        if (!en_s) begin
          st_nxt.pst = ovpc_pkg::PR_OFF;
        end
      end
    endcase
    // input OV gates switching without touching the sequencer
    st_nxt.sw_en = (st_nxt.pst == ovpc_pkg::PR_RUN) && !vin_s;
  end

  // State register, frozen while the enable is low
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= ST_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Field and status outputs straight from flops; latched_off is decoded from the state flops
  // input hysteresis select
  assign input_ov_hysteresis_sel = st_r.setup[ovpc_pkg::IN_HYS_BIT];
  assign input_ov_threshold_sel = st_r.setup[ovpc_pkg::IN_THR_LSB+:2];
  assign output_ov_recovery_sel = st_r.setup[ovpc_pkg::OUT_REC_BIT];
  assign output_ov_threshold_sel = st_r.setup[ovpc_pkg::OUT_THR_LSB+:2];
  assign feedback_pin_connect = st_r.setup[ovpc_pkg::FB_CON_BIT];
  assign output_ov_response_mode = st_r.setup[ovpc_pkg::MODE_BIT];
  assign switch_enable = st_r.sw_en;
  assign soft_start_req = st_r.ss_req;
  assign hiccup_active = st_r.hiccup;
  assign latched_off = st_r.pst == ovpc_pkg::PR_LATCH;
  // Open drain: the pin is only ever pulled low
  assign sda_pin_out = 1'h0;
  assign sda_pin_oe_n = !st_r.drv_low;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_in_hys_write: assert property (ce && wr_fire |=>
    input_ov_hysteresis_sel == $past(rx_byte[7]))
    else $error("input hysteresis select not taken from write");
  a_out_recovery: assert property (ce && wr_fire |=>
    output_ov_recovery_sel == $past(rx_byte[4]))
    else $error("output recovery select not taken from write");
  a_out_threshold: assert property (ce && wr_fire |=>
    output_ov_threshold_sel == $past(rx_byte[3:2]))
    else $error("output threshold code not taken from write");
  a_fb_isolated: assert property (ce && wr_fire && !rx_byte[1] |=>
    !feedback_pin_connect [*2])
    else $error("feedback pin connected after zero written");
  a_fb_routed: assert property (ce && wr_fire && rx_byte[1] |=>
    feedback_pin_connect)
    else $error("feedback pin not routed after one written");
  a_vin_ov_auto: assert property (ce && st_r.pst == ovpc_pkg::PR_RUN &&
    en_s && !vout_s |=> (switch_enable == !$past(vin_s)) &&
    st_r.pst == ovpc_pkg::PR_RUN)
    else $error("input OV did not gate or recover switching");
  a_stop_on_trip: assert property (ce && st_r.pst == ovpc_pkg::PR_RUN &&
    en_s && vout_s && !output_ov_response_mode |=>
    !switch_enable && st_r.pst == ovpc_pkg::PR_STOP && st_r.dly == 16'h0000)
    else $error("recoverable trip did not stop switching");
  a_hiccup_entry: assert property (ce && st_r.pst == ovpc_pkg::PR_RUN &&
    en_s && vout_s && !output_ov_response_mode && st_r.retried |=>
    hiccup_active)
    else $error("second trip did not enter hiccup");
  a_latch_entry: assert property (ce && st_r.pst == ovpc_pkg::PR_RUN &&
    en_s && vout_s && output_ov_response_mode |=> latched_off && !switch_enable)
    else $error("latch-off trip did not latch");
  a_latch_hold: assert property (latched_off && en_s |=> latched_off)
    else $error("latch released without enable low");
  a_setup_hold: assert property (!(ce && wr_fire) |=>
    $stable(st_r.setup))
    else $error("setup register changed without a write");
endmodule
`default_nettype wire

/* File: ovpc_top_tb_top.sv */
// Self-checking testbench for the over-voltage protection setup block
`timescale 1ns/1ns
`default_nettype none
module ovpc_top_tb_top;
  // Short retry delay keeps the hiccup runs brief
  localparam int RETRY = 8;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic scl = 1'b1;
  logic sda_m = 1'b1;
  logic en = 1'b0;
  logic vin = 1'b0;
  logic vout = 1'b0;
  logic sda_out, sda_oe_n, hys, rec, fb, mode, sw_en, ss, hic, lat;
  logic [1:0] ithr, othr;
  wire sda_w;
  wire [7:0] fields;
  int errors = 0;
  int checks_done = 0;

  // Open-drain data line with pull-up, low wins
  assign sda_w = sda_m & (sda_oe_n | sda_out);
  assign fields = {hys, ithr, rec, othr, fb, mode};

  always #5 sys_clk = ~sys_clk;

  ovpc_top #(.RETRY_CYC(RETRY)) u_dut (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ce(1'b1),
    .scl_pin(scl),
    .sda_pin_in(sda_w),
    .sda_pin_out(sda_out),
    .sda_pin_oe_n(sda_oe_n),
    .enable_pin(en),
    .vin_ov_cmp(vin),
    .vout_ov_cmp(vout),
    .input_ov_hysteresis_sel(hys),
    .input_ov_threshold_sel(ithr),
    .output_ov_recovery_sel(rec),
    .output_ov_threshold_sel(othr),
    .feedback_pin_connect(fb),
    .output_ov_response_mode(mode),
    .switch_enable(sw_en),
    .soft_start_req(ss),
    .hiccup_active(hic),
    .latched_off(lat)
  );

  // Inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Checks done %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Start or repeated start; also leaves SCL low
  task automatic i2c_start();
    sda_m = 1'b1;
    tick(10);
    scl = 1'b1;
    tick(10);
    sda_m = 1'b0;
    tick(10);
    scl = 1'b0;
    tick(10);
  endtask

  task automatic i2c_stop();
    sda_m = 1'b0;
    tick(10);
    scl = 1'b1;
    tick(10);
    sda_m = 1'b1;
    tick(10);
  endtask

  // SDA held a little after SCL falls so no false start or stop is seen
  task automatic bit_cyc(input logic d, output logic s);
    sda_m = d;
    tick(10);
    scl = 1'b1;
    tick(5);
    s = sda_w;
    tick(5);
    scl = 1'b0;
    tick(2);
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(b[i], s);
    bit_cyc(1'b1, ack);
  endtask

  task automatic get_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(1'b1, b[i]);
    bit_cyc(nack, s);
  endtask

  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d);
    logic a0, a1, a2;
    i2c_start();
    put_byte({ovpc_pkg::DEV_ADDR, 1'b0}, a0);
    put_byte(ptr, a1);
    put_byte(d, a2);
    i2c_stop();
    check("write_acks", {5'h00, a0, a1, a2}, 8'h00);
  endtask

  task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] d);
    logic a0, a1, a2;
    i2c_start();
    put_byte({ovpc_pkg::DEV_ADDR, 1'b0}, a0);
    put_byte(ptr, a1);
    i2c_start();
    put_byte({ovpc_pkg::DEV_ADDR, 1'b1}, a2);
    get_byte(1'b1, d);
    i2c_stop();
    check("read_acks", {5'h00, a0, a1, a2}, 8'h00);
  endtask

  // Bounded wait for the one-cycle soft start pulse
  task automatic wait_ss(output int n);
    n = 0;
    while (ss !== 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
  endtask

  initial begin
    logic [7:0] vals [9];
    logic [7:0] rd;
    logic a;
    int n;
    vals = '{8'h80, 8'h60, 8'h10, 8'h04, 8'h08, 8'h0c, 8'h02, 8'h01, 8'h00};
    tick(2);
    rstn = 1'b1;
    tick(6);
    check("fields_reset", fields, ovpc_pkg::SETUP_RST);
    rd_reg(ovpc_pkg::SETUP_OFS, rd);
    check("setup_reset", rd, ovpc_pkg::SETUP_RST);
    // Each field alone, every output trip code, feedback on then off
    foreach (vals[i]) begin
      wr_reg(ovpc_pkg::SETUP_OFS, vals[i]);
      check("fields", fields, vals[i]);
      rd_reg(ovpc_pkg::SETUP_OFS, rd);
      check("setup_rd", rd, vals[i]);
    end
    // Other offsets and a foreign address leave the setup alone
    wr_reg(ovpc_pkg::SETUP_OFS, 8'ha5);
    wr_reg(8'h0e, 8'hff);
    rd_reg(8'h0e, rd);
    check("unmapped_rd", rd, ovpc_pkg::UNMAPPED_RD);
    i2c_start();
    put_byte({~ovpc_pkg::DEV_ADDR, 1'b0}, a);
    check("foreign_ack", {7'h00, a}, 8'h01);
    put_byte(ovpc_pkg::SETUP_OFS, a);
    put_byte(8'h00, a);
    i2c_stop();
    rd_reg(ovpc_pkg::SETUP_OFS, rd);
    check("setup_kept", rd, 8'ha5);
    // Recoverable mode: stop, retry after the delay, then hiccup
    wr_reg(ovpc_pkg::SETUP_OFS, 8'h00);
    en = 1'b1;
    wait_ss(n);
    check("sw_on", {7'h00, sw_en}, 8'h01);
    vout = 1'b1;
    tick(5);
    check("trip_stop", {6'h00, sw_en, lat}, 8'h00);
    wait_ss(n);
    n = n + 5;
    check("retry_gap", {7'h00, n > RETRY && n <= RETRY + 6}, 8'h01);
    tick(6);
    check("hiccup", {6'h00, hic, sw_en}, 8'h02);
    wait_ss(n);
    check("hiccup_retry", {7'h00, n < 1000}, 8'h01);
    vout = 1'b0;
    en = 1'b0;
    tick(8);
    // Latch-off mode: input over-voltage still recovers by itself
    wr_reg(ovpc_pkg::SETUP_OFS, 8'h01);
    en = 1'b1;
    wait_ss(n);
    vin = 1'b1;
    tick(6);
    check("vin_ov", {6'h00, sw_en, lat}, 8'h00);
    vin = 1'b0;
    tick(6);
    check("vin_back", {6'h00, sw_en, lat}, 8'h02);
    // Output trip latches until enable is cycled
    vout = 1'b1;
    tick(6);
    vout = 1'b0;
    tick(3 * RETRY);
    check("latched", {6'h00, sw_en, lat}, 8'h01);
    en = 1'b0;
    tick(8);
    check("unlatched", {6'h00, sw_en, lat}, 8'h00);
    en = 1'b1;
    wait_ss(n);
    check("restart", {6'h00, sw_en, lat}, 8'h02);
    // Reset in mid-run drops the setup back to its reset value
    rstn = 1'b0;
    tick(2);
    check("fields_rst2", fields, ovpc_pkg::SETUP_RST);
    rstn = 1'b1;
    tick(6);
    rd_reg(ovpc_pkg::SETUP_OFS, rd);
    check("setup_rst2", rd, ovpc_pkg::SETUP_RST);
    end_of_test();
  end

  // Watchdog sized well above the roughly 21k cycles the sequence needs
  initial begin
    tick(80000);
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
